// ==== psc_pkg.sv ====
// Constants and types shared by the PID supervisory control block
package psc_pkg;

    // Clock and timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int SLEEP_TICK_NS = 100_000_000;
    localparam int SLEEP_TICK_CYCLES = SLEEP_TICK_NS / CLK_PERIOD_NS;
    localparam int TICK_CNT_W = 21;

    // Register bus widths
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;

    // Register offsets
    localparam logic [3:0] REG_SWITCHOVER_FREQ = 4'h0;
    localparam logic [3:0] REG_SUSPEND_DELAY = 4'h1;
    localparam logic [3:0] REG_SUSPEND_THRESHOLD = 4'h2;
    localparam logic [3:0] REG_SUSPEND_CANCEL = 4'h3;
    localparam logic [3:0] REG_PID_ACTION = 4'h4;
    localparam logic [3:0] REG_PANEL_SEL = 4'h5;
    localparam logic [3:0] REG_ANALOG_SEL = 4'h6;
    localparam logic [3:0] REG_OP_MODE = 4'h7;
    localparam logic [3:0] REG_TERM_FUNC_A = 4'h8;
    localparam logic [3:0] REG_TERM_FUNC_B = 4'h9;
    localparam logic [3:0] REG_TERM_FUNC_C = 4'hA;
    localparam logic [3:0] REG_BIAS_FREQ = 4'hB;
    localparam logic [3:0] REG_GAIN_FREQ = 4'hC;
    localparam logic [3:0] REG_MAX_FREQ = 4'hD;
    localparam logic [3:0] REG_MIN_FREQ = 4'hE;
    localparam logic [3:0] REG_STATUS = 4'hF;

    // Values after reset
    localparam logic [15:0] RST_SWITCHOVER = 16'h270F;
    localparam logic [15:0] RST_SUSPEND_DELAY = 16'h270F;
    localparam logic [15:0] RST_SUSPEND_THRESHOLD = 16'h0000;
    localparam logic [15:0] RST_SUSPEND_CANCEL = 16'h03E8;
    localparam logic [15:0] RST_PID_ACTION = 16'h0000;
    localparam logic [15:0] RST_MONITOR_SEL = 16'h0000;
    localparam logic [15:0] RST_OP_MODE = 16'h0000;
    localparam logic [15:0] RST_TERM_FUNC = 16'h0000;
    localparam logic [15:0] RST_BIAS_FREQ = 16'h0000;
    localparam logic [15:0] RST_GAIN_FREQ = 16'h1388;
    localparam logic [15:0] RST_MAX_FREQ = 16'h2EE0;
    localparam logic [15:0] RST_MIN_FREQ = 16'h0000;

    // Setting codes
    localparam logic [15:0] SETTING_OFF = 16'h270F;
    localparam logic [15:0] SWITCHOVER_MAX = 16'h9C40;
    localparam logic [15:0] PID_REVERSE = 16'h0014;
    localparam logic [15:0] PID_FORWARD = 16'h0015;
    localparam logic [15:0] OP_MODE_SWITCHOVER = 16'h0006;
    localparam logic [15:0] MON_SETPOINT = 16'h0034;
    localparam logic [15:0] MON_MEASURED = 16'h0035;
    localparam logic [15:0] MON_DEVIATION = 16'h0036;
    localparam logic [15:0] TERM_SUSPENDED = 16'h0046;
    localparam logic [15:0] TERM_PID_ACTIVE = 16'h002F;
    localparam logic [15:0] TERM_NEGATIVE = 16'h0064;
    localparam logic signed [17:0] DEV_OFFSET = 18'sh003E8;
    localparam logic signed [17:0] CANCEL_SCALE = 18'sh0000A;
    localparam int NUM_TERMS = 3;

    typedef enum logic [3:0] {
        PSC_IDLE = 4'b0001,
        PSC_NORMAL = 4'b0010,
        PSC_PID = 4'b0100,
        PSC_SLEEP = 4'b1000
    } psc_state_t;

endpackage

// ==== psc_sleep_timer.sv ====
// Suspension delay timer counting 0.1 s ticks while the PID output is low
`timescale 1ns/1ns
`default_nettype none
module psc_sleep_timer
    import psc_pkg::*;
#(
    parameter int TICK_CYCLES = SLEEP_TICK_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Control
    input wire logic lowLevel,
    input wire logic [15:0] delay,
    // Result
    output logic expired
);

    typedef struct packed {
        logic [TICK_CNT_W-1:0] prescale;
        logic [15:0] ticks;
        logic expired;
    } psc_timer_t;

    psc_timer_t r;
    psc_timer_t next_r;
    logic tick;

    always_comb begin
        next_r = r;
        tick = (r.prescale == TICK_CNT_W'(TICK_CYCLES - 1));
        if (!lowLevel) begin
            // Frequency back at or above threshold restarts the delay
            next_r.prescale = '0;
            next_r.ticks = '0;
            next_r.expired = 1'b0;
        end else begin
            next_r.prescale = tick ? '0 : r.prescale + 1'b1;
            if (tick && r.ticks != 16'hFFFF) begin
                next_r.ticks = r.ticks + 1'b1;
            end
            // Strictly longer than the delay before expiring
            next_r.expired = (r.ticks > delay);
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign expired = r.expired;

    restartLow_a: assert property (@(posedge mclk) disable iff (rst)
        !lowLevel |=> !expired)
        else $error("suspension timer expired without low output");

endmodule
`default_nettype wire

// ==== psc_top.sv ====
// Supervisory control around the PID loop: switchover, suspension, monitors
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
//
// Function
// - With switchover frequency set, run normally until output reaches it, then PID.
// - Once in PID, stay there even if output falls to switchover or below.
// - Stop output when PID frequency stays under threshold longer than delay.
// - While suspended, resume PID when deviation reaches cancel level minus 1000%.
// - While suspended: suspended flag on, running off, PID active on.
// - Suspended flag goes to terminals coded 70 or 170.
// - Monitor codes 52 set point, 53 measured, 54 deviation, 0.1% steps.
// - Deviation shown offset by 1000; never sent to analog monitor.
// - Speed step or jog input with PID selected stops PID, runs those instead.
// - Operation mode 6 makes PID invalid.
// - Stopped under power failure stop makes PID invalid.
// - PID output limited by bias/gain frequencies and max/min limits.
// - Remote operation disabled while PID is active.
// - Entering PID from normal running the frequency command restarts from 0 Hz.
// - PID only with action selection 20 or 21 and select input on.
// - Terminal codes 100 or above drive negative logic.
module psc_top
    import psc_pkg::*;
#(
    parameter int TICK_CYCLES = SLEEP_TICK_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [DATA_W-1:0] regRdata,
    // Pins
    input wire logic startCmd,
    input wire logic pidSelectInput,
    input wire logic speedStepHigh,
    input wire logic speedStepMiddle,
    input wire logic speedStepLow,
    input wire logic speedStepExtra,
    input wire logic jogInput,
    // Drive core, same clock
    input wire logic powerFailStopped,
    input wire logic [15:0] outputFreq,
    input wire logic [15:0] normalFreq,
    input wire logic [15:0] pidFreq,
    input wire logic [15:0] setPoint,
    input wire logic [15:0] measuredValue,
    // Drive control
    output logic [15:0] freqCmd,
    output logic pidRestart,
    output logic running,
    output logic pidActive,
    output logic suspended,
    output logic remoteEnable,
    // Terminals and monitors
    output logic [NUM_TERMS-1:0] termOut,
    output logic [15:0] panelMonitor,
    output logic [15:0] analogMonitor
);

    typedef struct packed {
        psc_state_t state;
        logic [6:0] sync1;
        logic [6:0] sync2;
        logic [15:0] switchover;
        logic [15:0] sleepDelay;
        logic [15:0] sleepThreshold;
        logic [15:0] cancelLevel;
        logic [15:0] pidAction;
        logic [15:0] panelSel;
        logic [15:0] analogSel;
        logic [15:0] opMode;
        logic [NUM_TERMS-1:0][15:0] termFunc;
        logic [15:0] biasFreq;
        logic [15:0] gainFreq;
        logic [15:0] maxFreq;
        logic [15:0] minFreq;
        logic [15:0] rdata;
        logic [15:0] freqCmd;
        logic pidRestart;
        logic running;
        logic pidActive;
        logic suspended;
        logic remoteEnable;
        logic [NUM_TERMS-1:0] termOut;
        logic [15:0] panelMon;
        logic [15:0] analogMon;
    } psc_regs_t;

    psc_regs_t r;
    psc_regs_t next_r;

    logic sleepExpired;
    logic sleepLow;
    logic startOn;
    logic pidSelected;
    logic pidInvalid;
    logic overrideOn;
    logic pidEnabled;
    logic switchReached;
    logic signed [17:0] deviation;
    logic signed [17:0] cancelThr;

    // Terminal decode: code, less 100 when 100+, picks the signal; 100+ inverts
    function automatic logic termDrive(input logic [15:0] code,
                                       input logic susp,
                                       input logic pid);
        logic [15:0] base;
        logic level;
        base = (code >= TERM_NEGATIVE) ? code - TERM_NEGATIVE : code;
        level = 1'b0;
        if (base == TERM_SUSPENDED) begin
            level = susp;
        end else if (base == TERM_PID_ACTIVE) begin
            level = pid;
        end
        return (code >= TERM_NEGATIVE) ? !level : level;
    endfunction

    // Monitor decode shared by the panel and the analog output
    function automatic logic [15:0] monSelect(input logic [15:0] sel,
                                              input logic analog,
                                              input logic [15:0] sp,
                                              input logic [15:0] mv,
                                              input logic signed [17:0] dv);
        logic [15:0] val;
        val = 16'h0000;
        case (sel)
            MON_SETPOINT: val = sp;
            MON_MEASURED: val = mv;
            // Offset lets negative deviation show without a sign
            MON_DEVIATION: val = analog ? 16'h0000 : 16'(dv + DEV_OFFSET);
            default: val = 16'h0000;
        endcase
        return val;
    endfunction

    psc_sleep_timer #(
        .TICK_CYCLES(TICK_CYCLES)
    ) sleepTimer (
        .mclk(mclk),
        .rst(rst),
        .lowLevel(sleepLow),
        .delay(r.sleepDelay),
        .expired(sleepExpired)
    );

    always_comb begin
        next_r = r;
        // Pin inputs pass two flip-flops before use
        next_r.sync1 = {jogInput, speedStepExtra, speedStepLow,
                        speedStepMiddle, speedStepHigh, pidSelectInput,
                        startCmd};
        next_r.sync2 = r.sync1;
        startOn = r.sync2[0];
        pidSelected = r.sync2[1] && (r.pidAction == PID_REVERSE
                      || r.pidAction == PID_FORWARD);
        overrideOn = pidSelected && (|r.sync2[6:2]);
        pidInvalid = (r.opMode == OP_MODE_SWITCHOVER)
                     || powerFailStopped;
        pidEnabled = pidSelected && !overrideOn && !pidInvalid;
        // Setting outside 0..400 Hz means no start-up phase
        switchReached = (r.switchover > SWITCHOVER_MAX)
                        || (outputFreq >= r.switchover);
        deviation = $signed({2'b00, setPoint}) - $signed({2'b00, measuredValue});
        cancelThr = ($signed({2'b00, r.cancelLevel}) - DEV_OFFSET)
                    * CANCEL_SCALE;
        sleepLow = (r.state == PSC_PID) && (r.sleepDelay != SETTING_OFF)
                   && (pidFreq < r.sleepThreshold);

        case (r.state)
            PSC_IDLE: begin
                if (startOn) begin
                    next_r.state = PSC_NORMAL;
                end
            end
            PSC_NORMAL: begin
                if (!startOn) begin
                    next_r.state = PSC_IDLE;
                end else if (pidEnabled && switchReached) begin
                    next_r.state = PSC_PID;
                end
            end
            PSC_PID: begin
                // Output frequency is not looked at here any more
                if (!startOn) begin
                    next_r.state = PSC_IDLE;
                end else if (!pidEnabled) begin
                    next_r.state = PSC_NORMAL;
                end else if (sleepExpired) begin
                    next_r.state = PSC_SLEEP;
                end else begin
                    next_r.state = PSC_PID;
                end
            end
            PSC_SLEEP: begin
                if (!startOn) begin
                    next_r.state = PSC_IDLE;
                end else if (!pidEnabled) begin
                    next_r.state = PSC_NORMAL;
                end else if (deviation >= cancelThr) begin
                    next_r.state = PSC_PID;
                end
            end
            default: next_r.state = PSC_IDLE;
        endcase

        // Outputs follow the next state so they line up with it
        next_r.suspended = (next_r.state == PSC_SLEEP);
        next_r.pidActive = (next_r.state == PSC_PID)
                           || (next_r.state == PSC_SLEEP);
        next_r.running = (next_r.state == PSC_NORMAL)
                         || (next_r.state == PSC_PID);
        next_r.remoteEnable = !next_r.pidActive;
        // Tells the PID core to build its command from zero
        next_r.pidRestart = (next_r.state == PSC_PID)
                            && (r.state == PSC_NORMAL);
        if (next_r.state == PSC_PID) begin
            if (next_r.pidRestart) begin
                next_r.freqCmd = 16'h0000;
            end else begin
                next_r.freqCmd = pidFreq;
                if (next_r.freqCmd < r.biasFreq) next_r.freqCmd = r.biasFreq;
                if (next_r.freqCmd > r.gainFreq) next_r.freqCmd = r.gainFreq;
                if (next_r.freqCmd < r.minFreq) next_r.freqCmd = r.minFreq;
                if (next_r.freqCmd > r.maxFreq) next_r.freqCmd = r.maxFreq;
            end
        end else if (next_r.state == PSC_NORMAL) begin
            next_r.freqCmd = normalFreq;
        end else begin
            next_r.freqCmd = 16'h0000;
        end

        for (int i = 0; i < NUM_TERMS; i++) begin
            next_r.termOut[i] = termDrive(r.termFunc[i], next_r.suspended,
                                          next_r.pidActive);
        end
        next_r.panelMon = monSelect(r.panelSel, 1'b0, setPoint,
                                    measuredValue, deviation);
        next_r.analogMon = monSelect(r.analogSel, 1'b1, setPoint,
                                     measuredValue, deviation);

        // Register writes
        if (regWrite) begin
            case (regAddr)
                REG_SWITCHOVER_FREQ: next_r.switchover = regWdata;
                REG_SUSPEND_DELAY: next_r.sleepDelay = regWdata;
                REG_SUSPEND_THRESHOLD: next_r.sleepThreshold = regWdata;
                REG_SUSPEND_CANCEL: next_r.cancelLevel = regWdata;
                REG_PID_ACTION: next_r.pidAction = regWdata;
                REG_PANEL_SEL: next_r.panelSel = regWdata;
                REG_ANALOG_SEL: next_r.analogSel = regWdata;
                REG_OP_MODE: next_r.opMode = regWdata;
                REG_TERM_FUNC_A: next_r.termFunc[0] = regWdata;
                REG_TERM_FUNC_B: next_r.termFunc[1] = regWdata;
                REG_TERM_FUNC_C: next_r.termFunc[2] = regWdata;
                REG_BIAS_FREQ: next_r.biasFreq = regWdata;
                REG_GAIN_FREQ: next_r.gainFreq = regWdata;
                REG_MAX_FREQ: next_r.maxFreq = regWdata;
                REG_MIN_FREQ: next_r.minFreq = regWdata;
                default: ;
            endcase
        end

        // Read data stands for one cycle only
        next_r.rdata = 16'h0000;
        if (regRead) begin
            case (regAddr)
                REG_SWITCHOVER_FREQ: next_r.rdata = r.switchover;
                REG_SUSPEND_DELAY: next_r.rdata = r.sleepDelay;
                REG_SUSPEND_THRESHOLD: next_r.rdata = r.sleepThreshold;
                REG_SUSPEND_CANCEL: next_r.rdata = r.cancelLevel;
                REG_PID_ACTION: next_r.rdata = r.pidAction;
                REG_PANEL_SEL: next_r.rdata = r.panelSel;
                REG_ANALOG_SEL: next_r.rdata = r.analogSel;
                REG_OP_MODE: next_r.rdata = r.opMode;
                REG_TERM_FUNC_A: next_r.rdata = r.termFunc[0];
                REG_TERM_FUNC_B: next_r.rdata = r.termFunc[1];
                REG_TERM_FUNC_C: next_r.rdata = r.termFunc[2];
                REG_BIAS_FREQ: next_r.rdata = r.biasFreq;
                REG_GAIN_FREQ: next_r.rdata = r.gainFreq;
                REG_MAX_FREQ: next_r.rdata = r.maxFreq;
                REG_MIN_FREQ: next_r.rdata = r.minFreq;
                REG_STATUS: next_r.rdata = {8'h00, r.state, r.remoteEnable,
                                            r.suspended, r.pidActive,
                                            r.running};
                default: next_r.rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            r <= '0;
            r.state <= PSC_IDLE;
            r.switchover <= RST_SWITCHOVER;
            r.sleepDelay <= RST_SUSPEND_DELAY;
            r.sleepThreshold <= RST_SUSPEND_THRESHOLD;
            r.cancelLevel <= RST_SUSPEND_CANCEL;
            r.pidAction <= RST_PID_ACTION;
            r.panelSel <= RST_MONITOR_SEL;
            r.analogSel <= RST_MONITOR_SEL;
            r.opMode <= RST_OP_MODE;
            r.termFunc <= {NUM_TERMS{RST_TERM_FUNC}};
            r.biasFreq <= RST_BIAS_FREQ;
            r.gainFreq <= RST_GAIN_FREQ;
            r.maxFreq <= RST_MAX_FREQ;
            r.minFreq <= RST_MIN_FREQ;
            r.remoteEnable <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign regRdata = r.rdata;
    assign freqCmd = r.freqCmd;
    assign pidRestart = r.pidRestart;
    assign running = r.running;
    assign pidActive = r.pidActive;
    assign suspended = r.suspended;
    assign remoteEnable = r.remoteEnable;
    assign termOut = r.termOut;
    assign panelMonitor = r.panelMon;
    assign analogMonitor = r.analogMon;

    sequence enterPid;
        r.state == PSC_NORMAL && pidEnabled && startOn && switchReached;
    endsequence

    sequence pidStarted;
        pidActive && pidRestart && freqCmd == 16'h0000;
    endsequence

    switchPid_a: assert property (@(posedge mclk) disable iff (rst)
        enterPid |=> pidStarted)
        else $error("no PID entry at switchover");
    stayPid_a: assert property (@(posedge mclk) disable iff (rst)
        r.state == PSC_PID && startOn && pidEnabled && !sleepExpired
        |=> r.state == PSC_PID)
        else $error("PID left without cause");
    sleepCancel_a: assert property (@(posedge mclk) disable iff (rst)
        r.state == PSC_SLEEP && startOn && pidEnabled && deviation >= cancelThr
        |=> !suspended && pidActive && running)
        else $error("suspension not cancelled");
    sleepFlags_a: assert property (@(posedge mclk) disable iff (rst)
        suspended |-> !running && pidActive)
        else $error("wrong flags while suspended");
    overridePid_a: assert property (@(posedge mclk) disable iff (rst)
        overrideOn |=> !pidActive)
        else $error("PID active under speed step or jog");
    modeSix_a: assert property (@(posedge mclk) disable iff (rst)
        r.opMode == OP_MODE_SWITCHOVER |=> !pidActive)
        else $error("PID active in mode 6");
    analogDev_a: assert property (@(posedge mclk) disable iff (rst)
        r.analogSel == MON_DEVIATION |=> analogMonitor == 16'h0000)
        else $error("deviation on analog monitor");
    remoteOff_a: assert property (@(posedge mclk) disable iff (rst)
        remoteEnable == !pidActive)
        else $error("remote enable wrong during PID");
    termSleep_a: assert property (@(posedge mclk) disable iff (rst)
        r.termFunc[0] == TERM_SUSPENDED && $stable(r.termFunc[0])
        |-> termOut[0] == suspended)
        else $error("terminal A does not show suspension");

endmodule
`default_nettype wire

// ==== psc_drive_model.sv ====
// Behavioural drive core: output frequency and PID result ramps
`timescale 1ns/1ns
`default_nettype none
module psc_drive_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // From the block
    input wire logic [15:0] freqCmd,
    input wire logic pidRestart,
    // Bench controls
    input wire logic [15:0] pidTarget,
    input wire logic [15:0] step,
    // To the block
    output logic [15:0] outputFreq,
    output logic [15:0] pidFreq
);
    // Ramps rather than jumps, so thresholds are crossed one after another
    function automatic logic [15:0] ramp(input logic [15:0] cur, tgt, st);
        if (tgt > cur) begin
            return (tgt - cur > st) ? cur + st : tgt;
        end
        return (cur - tgt > st) ? cur - st : tgt;
    endfunction
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            outputFreq <= 16'h0000;
            pidFreq <= 16'h0000;
        end else begin
            outputFreq <= ramp(outputFreq, freqCmd, step);
            // PID core restarts its result from zero when told to
            pidFreq <= pidRestart ? 16'h0000 : ramp(pidFreq, pidTarget, step);
        end
    end
endmodule
`default_nettype wire

// ==== tb_pid_supervisory_control.sv ====
// Self-checking bench for the PID supervisory control block
`timescale 1ns/1ns
`default_nettype none
module tb_pid_supervisory_control;
    logic mclk, rst, regWrite, regRead, startCmd, pidSel, powerFail;
    logic pidRestart, running, pidActive, suspended, remoteEnable;
    logic [3:0] regAddr;
    logic [4:0] ovr;
    logic [2:0] termOut;
    logic [1:0] stat;
    logic [15:0] regWdata, regRdata, normalFreq, setPoint, measuredValue;
    logic [15:0] outputFreq, pidFreq, freqCmd, pidTarget, step;
    logic [15:0] panelMonitor, analogMonitor;
    int errorCnt, checksDone;
    // Bit 0 pidActive, bit 1 suspended
    assign stat = {suspended, pidActive};
    psc_top #(.TICK_CYCLES(4)) uut (.mclk(mclk), .rst(rst),
        .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
        .regRead(regRead), .regRdata(regRdata), .startCmd(startCmd),
        .pidSelectInput(pidSel), .speedStepHigh(ovr[0]),
        .speedStepMiddle(ovr[1]), .speedStepLow(ovr[2]),
        .speedStepExtra(ovr[3]), .jogInput(ovr[4]),
        .powerFailStopped(powerFail), .outputFreq(outputFreq),
        .normalFreq(normalFreq), .pidFreq(pidFreq), .setPoint(setPoint),
        .measuredValue(measuredValue), .freqCmd(freqCmd),
        .pidRestart(pidRestart), .running(running), .pidActive(pidActive),
        .suspended(suspended), .remoteEnable(remoteEnable),
        .termOut(termOut), .panelMonitor(panelMonitor),
        .analogMonitor(analogMonitor));
    psc_drive_model drive (.mclk(mclk), .rst(rst), .freqCmd(freqCmd),
        .pidRestart(pidRestart), .pidTarget(pidTarget), .step(step),
        .outputFreq(outputFreq), .pidFreq(pidFreq));
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    task automatic printVerdict();
        $display("checks %0d errors %0d", checksDone, errorCnt);
        if (errorCnt == 0 && checksDone > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checksDone++;
        if (got !== exp) begin
            errorCnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge mclk);
        regWrite <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rdChk(input logic [3:0] a, input logic [15:0] exp);
        @(posedge mclk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge mclk);
        regRead <= 1'b0;
        #1 chk(regRdata, exp);
    endtask
    // Bounded wait on a status level, counted as a check
    task automatic waitLvl(input int k, input logic v);
        int n;
        n = 0;
        #1;
        while (stat[k] !== v && n < 200) begin
            @(posedge mclk);
            #1 n++;
        end
        chk({15'h0, stat[k]}, {15'h0, v});
    endtask
    task automatic tSwitch();
        wr(4'h0, 16'h03E8);
        wr(4'h4, 16'h0014);
        wr(4'hB, 16'h0064);
        wr(4'h8, 16'h0046);
        wr(4'h9, 16'h00AA);
        wr(4'hA, 16'h002F);
        pidTarget <= 16'h1770;
        normalFreq <= 16'h01F4;
        startCmd <= 1'b1;
        pidSel <= 1'b1;
        repeat (20) @(posedge mclk);
        #1 chk({15'h0, pidActive}, 16'h0000);
        chk(freqCmd, 16'h01F4);
        @(posedge mclk);
        normalFreq <= 16'h07D0;
        waitLvl(0, 1'b1);
        chk({15'h0, pidRestart}, 16'h0001);
        chk(freqCmd, 16'h0000);
        repeat (30) @(posedge mclk);
        #1 chk(freqCmd, 16'h1388);
        chk({15'h0, remoteEnable}, 16'h0000);
        @(posedge mclk);
        pidTarget <= 16'h0032;
        repeat (30) @(posedge mclk);
        #1 chk(freqCmd, 16'h0064);
        rdChk(4'hF, 16'h0043);
    endtask
    task automatic tSleep();
        wr(4'h3, 16'h03ED);
        setPoint <= 16'h0225;
        wr(4'h2, 16'h03E8);
        wr(4'h1, 16'h0001);
        waitLvl(1, 1'b1);
        chk(freqCmd, 16'h0000);
        chk({11'h0, running, pidActive, termOut}, 16'h000D);
        // Deviation one step short of the cancel level keeps it asleep
        repeat (10) @(posedge mclk);
        #1 chk({15'h0, suspended}, 16'h0001);
        @(posedge mclk);
        setPoint <= 16'h0226;
        pidTarget <= 16'h0BB8;
        waitLvl(1, 1'b0);
        chk({15'h0, pidActive}, 16'h0001);
    endtask
    task automatic tMonitor();
        wr(4'h5, 16'h0036);
        wr(4'h6, 16'h0036);
        repeat (3) @(posedge mclk);
        #1 chk(panelMonitor, 16'h041A);
        chk(analogMonitor, 16'h0000);
        @(posedge mclk);
        measuredValue <= 16'h0258;
        repeat (3) @(posedge mclk);
        #1 chk(panelMonitor, 16'h03B6);
        for (int i = 0; i < 2; i++) begin
            wr(4'h5, 16'h0034 + 16'(i));
            wr(4'h6, 16'h0034 + 16'(i));
            repeat (3) @(posedge mclk);
            #1 chk(panelMonitor, i == 0 ? setPoint : measuredValue);
            chk(analogMonitor, i == 0 ? setPoint : measuredValue);
        end
    endtask
    task automatic tOverride();
        for (int i = 0; i < 5; i++) begin
            @(posedge mclk);
            ovr <= 5'(1 << i);
            waitLvl(0, 1'b0);
            chk(freqCmd, normalFreq);
            chk({14'h0, running, remoteEnable}, 16'h0003);
            @(posedge mclk);
            ovr <= 5'h00;
            waitLvl(0, 1'b1);
        end
        wr(4'h7, 16'h0006);
        waitLvl(0, 1'b0);
        wr(4'h7, 16'h0000);
        waitLvl(0, 1'b1);
        powerFail <= 1'b1;
        waitLvl(0, 1'b0);
        @(posedge mclk);
        powerFail <= 1'b0;
        wr(4'h4, 16'h0000);
        waitLvl(0, 1'b0);
        wr(4'h4, 16'h0015);
        waitLvl(0, 1'b1);
        // Maximum limit below the gain frequency must still cap the command
        wr(4'hD, 16'h07D0);
        repeat (10) @(posedge mclk);
        #1 chk(freqCmd, 16'h07D0);
    endtask
    initial begin
        rst = 1'b1;
        {regWrite, regRead, startCmd, pidSel, powerFail} = 5'h00;
        {regAddr, ovr, regWdata, normalFreq, pidTarget} = '0;
        setPoint = 16'h01F4;
        measuredValue = 16'h01F4;
        step = 16'h01F4;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        rdChk(4'h0, 16'h270F);
        rdChk(4'h3, 16'h03E8);
        rdChk(4'hF, 16'h0018);
        tSwitch();
        tSleep();
        tMonitor();
        tOverride();
        printVerdict();
    end
    // The run needs well under 2000 cycles
    initial begin
        #(50 * 5000);
        errorCnt++;
        $display("[ERR] %0t watchdog expired", $time);
        printVerdict();
    end
endmodule
`default_nettype wire
